// File: core/tlr_pkg.sv
// How it works
// - Pointer 02h selects the low threshold register, read and write.
// - Pointer 03h selects the high threshold register, read and write.
// - Each threshold is a 12-bit two's complement result-scale value.
// - The low threshold sits in bits 15:4, bits 3:0 unused and reset zero.
// - The high threshold is bits 15:4; bits 3:0 unused, reset zero.
// - The low threshold resets to 4b00h, which is 75 degrees Celsius.
// - The high threshold resets to 5000h, which is 80 degrees Celsius.
// - Pointer 0Fh: read-only 16-bit identification, full variant only.
// - Identification upper byte is a fixed name code; writes ignored.
// - Threshold registers take one-byte and two-byte reads and writes.
// - Strapped pins pick the address, 2 to 32 choices as ADDR_SEL_W runs 1 to 5.
// - The result sits in the upper twelve bits, zeros below.
// - One-byte writes change bits 15:8; one-byte reads return 15:8.
package tlr_pkg;
    localparam logic [7:0]  TLR_PTR_RESULT  = 8'h00;
    localparam logic [7:0]  TLR_PTR_LOW     = 8'h02;
    localparam logic [7:0]  TLR_PTR_HIGH    = 8'h03;
    localparam logic [7:0]  TLR_PTR_IDENT   = 8'h0f;
    localparam logic [15:0] TLR_LOW_RESET   = 16'h4b00;
    localparam logic [15:0] TLR_HIGH_RESET  = 16'h5000;
    localparam int          TLR_VAL_MSB     = 15;
    localparam int          TLR_VAL_LSB     = 4;
    localparam logic [3:0]  TLR_NIBBLE_ZERO = 4'h0;
    localparam logic [3:0]  TLR_BITS_BYTE   = 4'h8;
    localparam int          TLR_ADDR_W      = 7;

    typedef struct packed {
        logic [11:0] high;
        logic [11:0] low;
    } tlr_limits_t;

    typedef enum logic [8:0] {
        TLR_IDLE     = 9'h001,
        TLR_ADDR     = 9'h002,
        TLR_ADDR_ACK = 9'h004,
        TLR_PTR      = 9'h008,
        TLR_PTR_ACK  = 9'h010,
        TLR_WDATA    = 9'h020,
        TLR_WACK     = 9'h040,
        TLR_RDATA    = 9'h080,
        TLR_RACK     = 9'h100
    } tlr_state_t;
endpackage : tlr_pkg

// File: core/tlr_regs.sv
`timescale 1ns/10ps
module tlr_regs
    import tlr_pkg::*;
#(
    parameter logic [6:0]  BASE_ADDR    = 7'h48,
    parameter int          ADDR_SEL_W   = 5,
    parameter bit          FULL_VARIANT = 1'b1,
    // Arbitrary identification value
    parameter logic [15:0] IDENT_VALUE  = 16'ha500
) (
    // Clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    // Two-wire bus pins
    input  wire logic                  SCL,
    input  wire logic                  SDA_IN,
    output logic                       SDA_OUT,
    output logic                       SDA_OE,
    // Address straps
    input  wire logic [ADDR_SEL_W-1:0] ADDR_SEL,
    // Conversion result and thresholds
    input  wire logic [11:0]           TEMP_RESULT,
    output tlr_limits_t                LIMITS
);

    if (ADDR_SEL_W < 1 || ADDR_SEL_W > 5) begin : g_bad_sel_w
        $error("ADDR_SEL_W must be 1 to 5");
    end

    // Pin synchronisers
    logic                  scl_s1_reg, scl_s2_reg, scl_s3_reg;
    logic                  sda_s1_reg, sda_s2_reg, sda_s3_reg;
    logic [ADDR_SEL_W-1:0] sel_s1_reg, sel_s2_reg;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_s3_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_s3_reg <= 1'b1;
            sel_s1_reg <= '0;
            sel_s2_reg <= '0;
        end else begin
            scl_s1_reg <= SCL;
            scl_s2_reg <= scl_s1_reg;
            scl_s3_reg <= scl_s2_reg;
            sda_s1_reg <= SDA_IN;
            sda_s2_reg <= sda_s1_reg;
            sda_s3_reg <= sda_s2_reg;
            sel_s1_reg <= ADDR_SEL;
            sel_s2_reg <= sel_s1_reg;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;
    logic [6:0] own_addr;

    assign scl_rise  = scl_s2_reg & ~scl_s3_reg;
    assign scl_fall  = ~scl_s2_reg & scl_s3_reg;
    assign bus_start = scl_s2_reg & scl_s3_reg & ~sda_s2_reg & sda_s3_reg;
    assign bus_stop  = scl_s2_reg & scl_s3_reg & sda_s2_reg & ~sda_s3_reg;

    always_comb begin
        own_addr = BASE_ADDR;
        own_addr[ADDR_SEL_W-1:0] = sel_s2_reg;
    end

    // Register read view by pointer
    function automatic logic [15:0] read_view(
        input logic [7:0]  ptr,
        input logic [15:0] low_v,
        input logic [15:0] high_v,
        input logic [11:0] temp_v
    );
        logic [15:0] v;
        v = 16'h0000;
        case (ptr)
            TLR_PTR_RESULT: v = {temp_v, TLR_NIBBLE_ZERO};
            TLR_PTR_LOW:    v = {low_v[TLR_VAL_MSB:TLR_VAL_LSB],
                                 TLR_NIBBLE_ZERO};
            TLR_PTR_HIGH:   v = {high_v[TLR_VAL_MSB:TLR_VAL_LSB],
                                 TLR_NIBBLE_ZERO};
            TLR_PTR_IDENT:  v = FULL_VARIANT ? IDENT_VALUE : 16'h0000;
            default:        v = 16'h0000;
        endcase
        return v;
    endfunction : read_view

    // Merge one received byte into a threshold register
    function automatic logic [15:0] merge_byte(
        input logic [15:0] cur,
        input logic        lo_byte,
        input logic [7:0]  data
    );
        logic [15:0] v;
        v = cur;
        if (lo_byte) begin
            v[7:0] = {data[7:4], TLR_NIBBLE_ZERO};
        end else begin
            v[15:8] = data;
        end
        return v;
    endfunction : merge_byte

    tlr_state_t  state_reg, state_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [7:0]  shift_reg, shift_next;
    logic [7:0]  tx_reg, tx_next;
    logic [7:0]  ptr_reg, ptr_next;
    logic        rw_reg, rw_next;
    logic        byte_reg, byte_next;
    logic        mack_reg, mack_next;
    logic        oe_reg, oe_next;
    logic [15:0] low_reg, low_next;
    logic [15:0] high_reg, high_next;
    logic [15:0] rd_word;

    assign rd_word = read_view(ptr_reg, low_reg, high_reg, TEMP_RESULT);

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        tx_next    = tx_reg;
        ptr_next   = ptr_reg;
        rw_next    = rw_reg;
        byte_next  = byte_reg;
        mack_next  = mack_reg;
        oe_next    = oe_reg;
        low_next   = low_reg;
        high_next  = high_reg;
        if (bus_start) begin
            state_next = TLR_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else if (bus_stop) begin
            state_next = TLR_IDLE;
            oe_next    = 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                TLR_ADDR, TLR_PTR, TLR_WDATA: begin
                    shift_next = {shift_reg[6:0], sda_s2_reg};
                    cnt_next   = cnt_reg + 4'h1;
                end
                TLR_RDATA: cnt_next = cnt_reg + 4'h1;
                TLR_RACK:  mack_next = ~sda_s2_reg;
                default:   cnt_next = cnt_reg;
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                TLR_ADDR: begin
                    if (cnt_reg == TLR_BITS_BYTE) begin
                        if (shift_reg[7:1] == own_addr) begin
                            state_next = TLR_ADDR_ACK;
                            rw_next    = shift_reg[0];
                            oe_next    = 1'b1;
                        end else begin
                            state_next = TLR_IDLE;
                        end
                    end
                end
                TLR_ADDR_ACK: begin
                    cnt_next  = 4'h0;
                    byte_next = 1'b0;
                    if (rw_reg) begin
                        state_next = TLR_RDATA;
                        tx_next    = rd_word[15:8];
                        oe_next    = ~rd_word[15];
                    end else begin
                        state_next = TLR_PTR;
                        oe_next    = 1'b0;
                    end
                end
                TLR_PTR: begin
                    if (cnt_reg == TLR_BITS_BYTE) begin
                        state_next = TLR_PTR_ACK;
                        ptr_next   = shift_reg;
                        oe_next    = 1'b1;
                    end
                end
                TLR_PTR_ACK, TLR_WACK: begin
                    state_next = TLR_WDATA;
                    cnt_next   = 4'h0;
                    byte_next  = (state_reg == TLR_WACK);
                    oe_next    = 1'b0;
                end
                TLR_WDATA: begin
                    if (cnt_reg == TLR_BITS_BYTE) begin
                        state_next = TLR_WACK;
                        oe_next    = 1'b1;
                        case (ptr_reg)
                            TLR_PTR_LOW:
                                low_next = merge_byte(low_reg, byte_reg,
                                                      shift_reg);
                            TLR_PTR_HIGH:
                                high_next = merge_byte(high_reg, byte_reg,
                                                       shift_reg);
                            default: low_next = low_reg;
                        endcase
                    end
                end
                TLR_RDATA: begin
                    if (cnt_reg == TLR_BITS_BYTE) begin
                        state_next = TLR_RACK;
                        oe_next    = 1'b0;
                    end else begin
                        tx_next = {tx_reg[6:0], 1'b0};
                        oe_next = ~tx_reg[6];
                    end
                end
                TLR_RACK: begin
                    cnt_next = 4'h0;
                    if (mack_reg) begin
                        // second byte is 7:0, then repeats
                        state_next = TLR_RDATA;
                        byte_next  = ~byte_reg;
                        tx_next    = byte_reg ? rd_word[15:8] : rd_word[7:0];
                        oe_next    = byte_reg ? ~rd_word[15] : ~rd_word[7];
                    end else begin
                        state_next = TLR_IDLE;
                        oe_next    = 1'b0;
                    end
                end
                default: state_next = TLR_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_reg <= TLR_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg    <= 8'h00;
            ptr_reg   <= TLR_PTR_RESULT;
            rw_reg    <= 1'b0;
            byte_reg  <= 1'b0;
            mack_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            low_reg   <= TLR_LOW_RESET;
            high_reg  <= TLR_HIGH_RESET;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            tx_reg    <= tx_next;
            ptr_reg   <= ptr_next;
            rw_reg    <= rw_next;
            byte_reg  <= byte_next;
            mack_reg  <= mack_next;
            oe_reg    <= oe_next;
            low_reg   <= low_next;
            high_reg  <= high_next;
        end
    end

    // Open-drain: only ever pulls low
    logic        sda_out_reg;
    tlr_limits_t limits_reg;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            sda_out_reg <= 1'b0;
            limits_reg  <= '0;
        end else begin
            sda_out_reg <= 1'b0;
            limits_reg.low  <= low_next[TLR_VAL_MSB:TLR_VAL_LSB];
            limits_reg.high <= high_next[TLR_VAL_MSB:TLR_VAL_LSB];
        end
    end

    assign SDA_OUT = sda_out_reg;
    assign SDA_OE  = oe_reg;
    assign LIMITS  = limits_reg;

endmodule : tlr_regs

// File: tb/tlr_regs_properties.sv
`timescale 1ns/10ps
module tlr_props
    import tlr_pkg::*;
(
    // Clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // Pins and thresholds
    input wire logic        SCL,
    input wire logic        SDA_OUT,
    input wire logic        SDA_OE,
    input wire tlr_limits_t LIMITS
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    a_out_stays_low:
        assert property (SDA_OUT == 1'b0) else $error("SDA driven high");
    a_low_reset_val:
        assert property ($fell(RST) |-> ##[0:2] LIMITS.low == 12'h4b0)
        else $error("Low threshold reset value wrong");
    a_high_reset_val:
        assert property ($fell(RST) |-> ##[0:2] LIMITS.high == 12'h500)
        else $error("High threshold reset value wrong");
    a_oe_scl_low:
        assert property ($changed(SDA_OE) |-> !SCL)
        else $error("SDA enable moved while SCL high");
    a_limits_scl_low:
        assert property ($changed(LIMITS) && !$past(RST) && !$past(RST, 2)
            |-> !SCL) else $error("Threshold moved while SCL high");
    a_regs_apart:
        assert property ($changed(LIMITS.low) && !$past(RST)
            && !$past(RST, 2) |-> $stable(LIMITS.high))
        else $error("Both thresholds changed together");
    a_oe_min_hold:
        assert property ($rose(SDA_OE) |-> SDA_OE [*8])
        else $error("SDA enable pulse too short");
    a_oe_release:
        assert property ($rose(SDA_OE) |-> ##[1:1000] !SDA_OE)
        else $error("SDA enable never released");

    c_oe_drive: cover property ($rose(SDA_OE));
    c_low_write: cover property ($changed(LIMITS.low));
    c_high_write: cover property ($changed(LIMITS.high));
endmodule : tlr_props

bind tlr_regs tlr_props tlr_props_i (.CORE_CLK(CORE_CLK), .RST(RST),
    .SCL(SCL), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .LIMITS(LIMITS));

// File: tb/tlr_host_model.sv
`timescale 1ns/10ps
module tlr_host_model (
    // Clock
    input  wire logic clk,
    // Bus wires
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic bus_bit(input logic b, output logic r);
        sda_low = !b;
        w(5);
        scl = 1'b1;
        w(5);
        r = sda;
        w(5);
        scl = 1'b0;
        w(5);
    endtask : bus_bit
    task automatic start();
        sda_low = 1'b0;
        w(5);
        scl = 1'b1;
        w(10);
        sda_low = 1'b1;
        w(10);
        scl = 1'b0;
        w(5);
    endtask : start
    task automatic stop();
        sda_low = 1'b1;
        w(5);
        scl = 1'b1;
        w(10);
        sda_low = 1'b0;
        w(10);
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bus_bit(d[i], r);
        bus_bit(1'b1, r);
        ack = !r;
    endtask : wbyte
    task automatic rbyte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bus_bit(1'b1, d[i]);
        bus_bit(nack, r);
    endtask : rbyte
endmodule : tlr_host_model

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import tlr_pkg::*;
    localparam logic [6:0] DEV = 7'h4a;
    // Arbitrary identification value
    localparam logic [15:0] ID_CODE = 16'hc300;
    logic        clk, rst, scl, sda, oe, sda_out, host_low, ack;
    logic [4:0]  addr_sel;
    logic [11:0] temp;
    tlr_limits_t limits;
    int          bad_count, checks;

    assign sda = (oe ? sda_out : 1'b1) & !host_low;
    tlr_regs #(.IDENT_VALUE(ID_CODE)) tlr_regs_i (.CORE_CLK(clk), .RST(rst),
        .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(oe),
        .ADDR_SEL(addr_sel), .TEMP_RESULT(temp), .LIMITS(limits));
    tlr_host_model tlr_host_model_i (.clk(clk), .sda(sda), .scl(scl),
        .sda_low(host_low));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic [7:0] d);
        tlr_host_model_i.wbyte(d, ack);
        chk(16'(ack), 16'h0001);
    endtask : wb
    task automatic reg_wr(input logic [7:0] p, input logic [15:0] d,
                          input int n);
        tlr_host_model_i.start();
        wb({DEV, 1'b0});
        wb(p);
        if (n > 0) wb(d[15:8]);
        if (n > 1) wb(d[7:0]);
        tlr_host_model_i.stop();
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] p, input int n,
                          input logic [15:0] exp);
        logic [15:0] r;
        r = 16'h0000;
        tlr_host_model_i.start();
        wb({DEV, 1'b0});
        wb(p);
        tlr_host_model_i.start();
        wb({DEV, 1'b1});
        tlr_host_model_i.rbyte(n == 1, r[15:8]);
        if (n > 1) tlr_host_model_i.rbyte(1'b1, r[7:0]);
        tlr_host_model_i.stop();
        chk(r, exp);
    endtask : reg_rd
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    initial begin
        #200000;
        bad_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        results();
    end
    initial begin
        rst = 1'b1;
        addr_sel = 5'h0a;
        temp = 12'h7ff;
        bad_count = 0;
        checks = 0;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({4'h0, limits.low}, 16'h04b0);
        chk({4'h0, limits.high}, 16'h0500);
        reg_rd(8'h02, 2, 16'h4b00);
        reg_rd(8'h03, 2, 16'h5000);
        reg_wr(8'h02, 16'h123f, 2);
        reg_rd(8'h02, 2, 16'h1230);
        reg_rd(8'h02, 1, 16'h1200);
        chk({4'h0, limits.low}, 16'h0123);
        reg_wr(8'h03, 16'h5aff, 1);
        reg_rd(8'h03, 2, 16'h5a00);
        chk({4'h0, limits.high}, 16'h05a0);
        chk({4'h0, limits.low}, 16'h0123);
        reg_rd(8'h0f, 2, ID_CODE);
        reg_wr(8'h0f, 16'h0000, 2);
        reg_rd(8'h0f, 2, ID_CODE);
        reg_rd(8'h0f, 1, {ID_CODE[15:8], 8'h00});
        reg_rd(8'h00, 2, 16'h7ff0);
        temp = 12'h800;
        reg_rd(8'h00, 2, 16'h8000);
        reg_rd(8'h01, 1, 16'h0000);
        reg_wr(8'h02, 16'hfe7f, 2);
        chk({4'h0, limits.low}, 16'h0fe7);
        // Mid-run reset must restore both thresholds
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({4'h0, limits.high}, 16'h0500);
        reg_rd(8'h02, 2, 16'h4b00);
        tlr_host_model_i.start();
        tlr_host_model_i.wbyte({7'h4b, 1'b0}, ack);
        tlr_host_model_i.stop();
        chk(16'(ack), 16'h0000);
        results();
    end
endmodule : testbench
